// File: verilog/nsb_port.sv
/*
  Synchronous bus front end of a flash target: samples the host pins,
  decodes bus modes, latches command and address bytes, captures input
  data on strobe edges and drives output data with a delayed strobe.
  Assumes the host clock is far slower than mclk and array busy flags
  arrive on mclk.
*/
module nsb_port
  import nsb_pkg::*;
#(
  parameter int DIES = nsb_pkg::DIE_UNITS,
  parameter int MODE_SETTLE = nsb_pkg::MODE_SETTLE_CYC,
  parameter int ENABLE_SETTLE = nsb_pkg::ENABLE_SETTLE_CYC,
  parameter int DEPTH = nsb_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Interface selection, from device configuration
  input wire logic sync_active,
  // Host pins, raw levels
  input wire nsb_pkg::nsb_pins_t pins_in,
  // Data bus drive
  output logic [7:0] dq_out,
  output logic dq_oe,
  // Data strobe drive
  output logic dqs_out,
  output logic dqs_oe,
  // Ready/busy open drain
  output logic rb_out,
  output logic rb_oe,
  // Array status
  input wire logic [DIES-1:0] die_busy,
  // Latched command and address
  output nsb_pkg::nsb_latch_t cmd_out,
  output nsb_pkg::nsb_latch_t addr_out,
  output logic cmd_refused,
  // Received data stream
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_full,
  // Transmit data stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_take,
  // Status
  output nsb_pkg::nsb_mode_t mode,
  output logic enabled,
  output logic standby,
  output logic settle_busy
);

  import nsb_pkg::*;

  // Synchronised pins and previous sample
  nsb_pins_t pins_s;
  logic clk_prev_ff;
  logic dqs_prev_ff;
  logic ce_prev_ff;
  // Clock and strobe edges
  logic clk_rise;
  logic clk_fall;
  logic dqs_edge;
  // Mode and counters
  nsb_mode_t mode_ff;
  nsb_mode_t nxt_mode;
  logic [7:0] en_cnt_ff;
  logic [7:0] settle_cnt_ff;
  logic enh_pending_ff;
  logic any_busy;
  logic selected;
  // Decoded latch requests
  logic cmd_cycle;
  logic addr_cycle;
  logic cmd_ok;
  logic addr_ok;
  // Delayed bus clock for strobe output
  logic [STROBE_OUT_DELAY_CYC-1:0] clk_pipe_ff;
  logic dly_edge;
  logic dly_prev_ff;
  // Receive FIFO fill and drain sides
  logic rx_in_valid;
  logic rx_in_ready;
  logic rx_fifo_valid;
  logic [7:0] rx_fifo_data;

  // Pin synchroniser, all host pins
  nsb_sync #(
    .W($bits(nsb_pins_t)),
    .RST_VAL(PINS_RST)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(pins_in),
    .dout(pins_s)
  );

  // Edge history of sampled pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_ff <= 1'b0;
      dqs_prev_ff <= 1'b0;
      ce_prev_ff <= 1'b1;
    end else begin
      clk_prev_ff <= pins_s.bus_clk;
      dqs_prev_ff <= pins_s.dqs;
      ce_prev_ff <= pins_s.ce_n;
    end
  end

  assign clk_rise = sync_active && pins_s.bus_clk && !clk_prev_ff;
  assign clk_fall = sync_active && !pins_s.bus_clk && clk_prev_ff;
  assign dqs_edge = pins_s.dqs != dqs_prev_ff;
  assign any_busy = |die_busy;
  assign selected = sync_active && !pins_s.ce_n;

  assign cmd_cycle = clk_rise && (mode_ff != M_STANDBY) && (mode_ff != M_ENABLING) &&
                     pins_s.cle && !pins_s.ale && pins_s.dir_wr && selected;
  assign addr_cycle = clk_rise && (mode_ff != M_STANDBY) && (mode_ff != M_ENABLING) &&
                      !pins_s.cle && pins_s.ale && pins_s.dir_wr && selected;
  assign cmd_ok = !any_busy || is_status_cmd(pins_s.dq);
  assign addr_ok = !any_busy || enh_pending_ff;

  // Next bus mode
  always_comb begin
    nxt_mode = mode_ff;
    if (!selected) begin
      nxt_mode = M_STANDBY;
    end else if (mode_ff == M_STANDBY) begin
      nxt_mode = M_ENABLING;
    end else if (mode_ff == M_ENABLING) begin
      if (clk_rise && (en_cnt_ff >= 8'(ENABLE_SETTLE - 1))) begin
        nxt_mode = M_IDLE;
      end
    end else if (clk_rise) begin
      case ({pins_s.cle, pins_s.ale, pins_s.dir_wr})
        3'b001: nxt_mode = M_IDLE;
        3'b000: nxt_mode = M_DRIVE;
        3'b101: nxt_mode = M_CMD;
        3'b011: nxt_mode = M_ADDR;
        3'b111: nxt_mode = M_DIN;
        3'b110: nxt_mode = M_DOUT;
        default: nxt_mode = M_DRIVE;
      endcase
    end
  end

  // Mode register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= M_STANDBY;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_cnt_ff <= 8'h00;
    end else if (mode_ff != M_ENABLING) begin
      en_cnt_ff <= 8'h00;
    end else if (clk_rise) begin
      en_cnt_ff <= en_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_ff <= 8'h00;
    end else if (!selected) begin
      settle_cnt_ff <= 8'h00;
    end else if (cmd_cycle || addr_cycle || (clk_rise && nxt_mode == M_IDLE &&
                 mode_ff != M_IDLE)) begin
      settle_cnt_ff <= 8'(MODE_SETTLE);
    end else if (clk_rise && settle_cnt_ff != 8'h00) begin
      settle_cnt_ff <= settle_cnt_ff - 8'h01;
    end
  end

  // Command latch and write guard
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_out <= '0;
      cmd_refused <= 1'b0;
      enh_pending_ff <= 1'b0;
    end else begin
      cmd_out.valid <= 1'b0;
      cmd_refused <= 1'b0;
      if (cmd_cycle && cmd_ok) begin
        if (is_prog_erase(pins_s.dq) && !pins_s.wp_n) begin
          cmd_refused <= 1'b1;
        end else begin
          cmd_out.valid <= 1'b1;
          cmd_out.value <= pins_s.dq;
        end
        enh_pending_ff <= pins_s.dq == CMD_STATUS_ENH;
      end
    end
  end

  // Address latch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_out <= '0;
    end else begin
      addr_out.valid <= 1'b0;
      if (addr_cycle && addr_ok) begin
        addr_out.valid <= 1'b1;
        addr_out.value <= pins_s.dq;
      end
    end
  end

  assign rx_in_valid = (mode_ff == M_DIN) && dqs_edge && !any_busy;

  // Receive buffer
  nsb_fifo #(
    .W(DATA_W),
    .DEPTH(DEPTH)
  ) u_rx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data(pins_s.dq),
    .out_valid(rx_fifo_valid),
    .out_ready(rx_ready),
    .out_data(rx_fifo_data)
  );

  // Receive outputs and full flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_full <= 1'b0;
    end else begin
      rx_full <= !rx_in_ready;
    end
  end
  assign rx_valid = rx_fifo_valid;
  assign rx_data = rx_fifo_data;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_pipe_ff <= '0;
      dly_prev_ff <= 1'b0;
    end else begin
      clk_pipe_ff <= STROBE_OUT_DELAY_CYC'({clk_pipe_ff, pins_s.bus_clk});
      dly_prev_ff <= clk_pipe_ff[STROBE_OUT_DELAY_CYC-1];
    end
  end
  assign dly_edge = clk_pipe_ff[STROBE_OUT_DELAY_CYC-1] != dly_prev_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dq_oe <= 1'b0;
      dqs_oe <= 1'b0;
    end else begin
      dq_oe <= (mode_ff == M_DRIVE) || (mode_ff == M_DOUT);
      // strobe enabled only in sync mode
      dqs_oe <= sync_active && ((mode_ff == M_DRIVE) || (mode_ff == M_DOUT));
    end
  end

  // Output strobe and data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dqs_out <= 1'b0;
      dq_out <= BYTE_RST;
      tx_take <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      if (mode_ff == M_DOUT) begin
        dqs_out <= clk_pipe_ff[STROBE_OUT_DELAY_CYC-1];
        if (dly_edge && tx_valid && !tx_take) begin
          dq_out <= tx_data;
          tx_take <= 1'b1;
        end
      end else begin
        dqs_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      standby <= 1'b0;
      enabled <= 1'b0;
      settle_busy <= 1'b0;
      mode <= M_STANDBY;
      rb_out <= 1'b0;
      rb_oe <= 1'b0;
    end else begin
      standby <= ce_prev_ff && pins_s.ce_n && !any_busy;
      enabled <= (mode_ff != M_STANDBY) && (mode_ff != M_ENABLING);
      settle_busy <= settle_cnt_ff != 8'h00;
      mode <= mode_ff;
      rb_out <= 1'b0;
      // Busy pulls ready/busy low even when deselected
      rb_oe <= any_busy;
    end
  end

endmodule : nsb_port

// File: verilog/nsb_pkg.sv
/*
  Shared constants, carrier types and mode encoding for the synchronous
  flash bus front end and its helpers.
  Assumes a single 100 MHz core clock; bus pins are sampled, never used as clocks.
*/
// Overview of operation
// - Sync mode: clock, direction pins, strobe enabled
// - Direction high host drives; low device drives
// - Decode modes from select, latches, direction
// - Input data captured on host strobe edges
// - Output strobe follows clock after delay
// - Enable waits settle time, then idle
// - Idle before deselect; deselect disables target
// - Standby when deselected and no die busy
// - Idle: both inputs, nothing latched
// - Driving: strobe low, data bus driven
// - Command byte latched on clock rise
// - Busy die ignores commands except status reads
// - Address byte latched on clock rise
// - Busy die ignores addresses except after 78h
// - Mode settle starts at latching clock edge
// - Write guard low refuses program, erase
package nsb_pkg;

  // Core clock period
  localparam int CLK_PERIOD_NS = 10;
  // Strobe output delay as a time
  localparam int STROBE_OUT_DELAY_NS = 20;
  // Strobe output delay in core cycles, rounded down, at least one
  localparam int STROBE_OUT_DELAY_CYC = (STROBE_OUT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                        (STROBE_OUT_DELAY_NS / CLK_PERIOD_NS);
  // Settle times in bus clock rising edges
  localparam int MODE_SETTLE_CYC = 2;
  localparam int ENABLE_SETTLE_CYC = 2;
  // Data path sizes
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int DIE_UNITS = 1;
  // Command codes
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_PROG_CACHE = 8'h85;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Bus pins as one bundle
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic bus_clk;
    logic dir_wr;
    logic dqs;
    logic [7:0] dq;
    logic wp_n;
  } nsb_pins_t;

  // Idle pin levels held by the synchroniser in reset: deselected, host owns the bus
  localparam nsb_pins_t PINS_RST = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, bus_clk: 1'b0,
                                     dir_wr: 1'b1, dqs: 1'b0, dq: 8'h00, wp_n: 1'b1};

  // Latched byte with its one-cycle strobe
  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } nsb_latch_t;

  // Bus modes, Gray coded along enable path
  typedef enum logic [2:0] {
    M_STANDBY = 3'b000,
    M_ENABLING = 3'b001,
    M_IDLE = 3'b011,
    M_CMD = 3'b010,
    M_ADDR = 3'b110,
    M_DIN = 3'b111,
    M_DOUT = 3'b101,
    M_DRIVE = 3'b100
  } nsb_mode_t;

  // Commands that alter the array
  function automatic logic is_prog_erase(input logic [7:0] c);
    is_prog_erase = (c == CMD_PROG) || (c == CMD_PROG_CACHE) || (c == CMD_ERASE);
  endfunction : is_prog_erase

  // Commands a busy die still takes
  function automatic logic is_status_cmd(input logic [7:0] c);
    is_status_cmd = (c == CMD_STATUS) || (c == CMD_STATUS_ENH);
  endfunction : is_status_cmd

endpackage : nsb_pkg

// File: verilog/nsb_sync.sv
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes inputs are asynchronous to mclk; only the second stage is used.
*/
module nsb_sync #(
  parameter int W = 15,
  // Reset level, set to the pins' idle levels so no false edge follows reset
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Raw and synchronised levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // First stage, read only by second stage
  logic [W-1:0] meta_ff;

  // Two stage capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end

endmodule : nsb_sync

// File: verilog/nsb_fifo.sv
/*
  Parameterised FIFO with valid/ready on both sides and registered read data.
  Assumes writer and reader share mclk.
*/
module nsb_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // Storage and pointers
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // Honest full and empty
  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count_ff != '0) && (!out_valid || out_ready);

  // Memory write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + AW'(1);
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_ff[rd_ptr_ff];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : nsb_fifo

// File: sim/nsb_port_assertions.sv
/*
  Checker for the bus front end: mode, latch and drive relations at its ports.
  Assumes it is bound to every nsb_port instance.
*/
module nsb_port_assertions
  import nsb_pkg::*;
#(
  parameter int DIES = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Observed ports
  input wire logic [DIES-1:0] die_busy,
  input wire logic dq_oe,
  input wire logic dqs_out,
  input wire logic dqs_oe,
  input wire nsb_pkg::nsb_latch_t cmd_out,
  input wire nsb_pkg::nsb_latch_t addr_out,
  input wire logic cmd_refused,
  input wire nsb_pkg::nsb_mode_t mode,
  input wire logic standby
);
  // One domain only
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  refuse_no_cmd_a: assert property (cmd_refused |-> !cmd_out.valid)
    else $error("Refused command was latched");
  busy_status_a: assert property ((cmd_out.valid && die_busy != '0 &&
    $past(die_busy) != '0 && $past(die_busy, 2) != '0) |->
    (cmd_out.value == CMD_STATUS || cmd_out.value == CMD_STATUS_ENH))
    else $error("Busy die took a non-status command");
  cmd_mode_a: assert property (cmd_out.valid |=> mode == M_CMD)
    else $error("Command latched outside command mode");
  addr_mode_a: assert property (addr_out.valid |=> mode == M_ADDR)
    else $error("Address latched outside address mode");
  drive_dir_a: assert property (dq_oe |-> mode inside {M_DRIVE, M_DOUT})
    else $error("Data bus driven while host owns it");
  idle_quiet_a: assert property ((mode == M_IDLE ##1 mode == M_IDLE) |->
    !dq_oe && !dqs_oe && !$past(cmd_out.valid) && !$past(addr_out.valid))
    else $error("Activity during bus idle");
  drive_low_a: assert property ((mode == M_DRIVE)[*4] |-> dq_oe && !dqs_out)
    else $error("Bus driving without low strobe");
  standby_idle_a: assert property (standby |-> $past(die_busy) == '0)
    else $error("Standby while a die is busy");
  enable_path_a: assert property (mode == M_STANDBY |=>
    mode inside {M_STANDBY, M_ENABLING})
    else $error("Standby left without enable settle");
  enable_exit_a: assert property (mode == M_ENABLING |=>
    mode inside {M_ENABLING, M_IDLE, M_STANDBY})
    else $error("Enable settle did not end in idle");
endmodule : nsb_port_assertions

bind nsb_port nsb_port_assertions #(.DIES(DIES)) u_chk (.mclk(mclk), .rst_n(rst_n),
  .die_busy(die_busy), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
  .cmd_out(cmd_out), .addr_out(addr_out), .cmd_refused(cmd_refused), .mode(mode),
  .standby(standby));

// File: sim/nsb_host_model.sv
/*
  Host controller model: makes the bus clock and drives the control pins.
  Assumes the testbench calls its tasks one at a time.
*/
module nsb_host_model
  import nsb_pkg::*;
(
  // Core clock
  input wire logic mclk,
  // Device drive
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic dqs_out,
  input wire logic dqs_oe,
  // Resolved pins
  output nsb_pkg::nsb_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Host pin levels
  logic clk_run, bclk, ce_n, cle, ale, dir, dqs_h, wp_n;
  logic [7:0] dq_h;

  // clock stands still when stopped, 80 ns period
  initial begin
    {clk_run, bclk, cle, ale, dqs_h, dq_h} = '0;
    {ce_n, dir, wp_n} = 3'b111;
    #3;
    forever #40 bclk = clk_run & ~bclk;
  end

  // device wins when it drives; released lines show the inverse level
  assign pins = '{ce_n, cle, ale, bclk, dir, dqs_oe ? dqs_out : (dir ? dqs_h : ~dqs_h),
                  dq_oe ? dq_out : (dir ? dq_h : ~dq_h), wp_n};

  // One bus clock with the given latch pair, direction and byte
  task automatic cyc(input logic c, input logic a, input logic d, input logic [7:0] v);
    @(negedge bclk);
    @(posedge mclk);
    cle <= c;
    ale <= a;
    dir <= d;
    dq_h <= v;
    @(posedge bclk);
  endtask : cyc

  // Idle cycles with host owning the bus
  task automatic idle(input int k);
    repeat (k) cyc(1'b0, 1'b0, 1'b1, dq_h);
  endtask : idle

  // byte, then idle through the settle time
  task automatic put(input logic c, input logic a, input logic [7:0] v);
    cyc(c, a, 1'b1, v);
    idle(MODE_SETTLE_CYC + 1);
  endtask : put

  // clock runs, latches low, before select changes
  task automatic sel(input logic n);
    @(posedge mclk);
    clk_run <= 1'b1;
    idle(3);
    @(posedge mclk);
    ce_n <= n;
    repeat (2) @(posedge mclk);
    clk_run <= ~n;
  endtask : sel

  // device owns the bus, latches low
  task automatic drive(input int k);
    repeat (k) cyc(1'b0, 1'b0, 1'b0, dq_h);
  endtask : drive

  task automatic dout(input int k);
    repeat (k) cyc(1'b1, 1'b1, 1'b0, dq_h);
  endtask : dout

  // strobe n bytes, one per edge, then pause back to idle
  task automatic din(input int n, input logic [7:0] base);
    cyc(1'b1, 1'b1, 1'b1, base);
    repeat (4) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      dq_h <= base + 8'(i);
      repeat (2) @(posedge mclk);
      dqs_h <= ~dqs_h;
      repeat (2) @(posedge mclk);
    end
    idle(MODE_SETTLE_CYC + 1);
  endtask : din
endmodule : nsb_host_model

// File: sim/tb_top.sv
/*
  Testbench for the bus front end, driving it through the host model.
  Assumes the checker is bound to the design by its own file.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import nsb_pkg::*;
  // Design connections
  logic mclk = 1'b0, rst_n, rx_ready, tx_valid, dq_oe, dqs_out, dqs_oe, rb_out, rb_oe;
  logic sync_act, dqs_prev;
  logic cmd_refused, rx_valid, rx_full, tx_take, enabled, standby, settle_busy;
  logic [0:0] die_busy;
  logic [7:0] dq_out, rx_data;
  logic [7:0] tx_data = 8'h00;
  nsb_pins_t pins;
  nsb_latch_t cmd_out, addr_out;
  nsb_mode_t mode;
  // Bench tallies
  int failures = 0, n_compared = 0, n_cmd = 0, n_addr = 0, n_ref = 0, n_take = 0, n_tog = 0;
  int n_dq_bad = 0;
  logic [7:0] last_cmd, last_addr;
  logic [7:0] rx_q[$];

  // 100 MHz core clock
  always #5 mclk = ~mclk;

  nsb_port dut (.mclk(mclk), .rst_n(rst_n), .sync_active(sync_act), .pins_in(pins),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .rb_out(rb_out),
    .rb_oe(rb_oe), .die_busy(die_busy), .cmd_out(cmd_out), .addr_out(addr_out),
    .cmd_refused(cmd_refused), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_full(rx_full), .tx_data(tx_data), .tx_valid(tx_valid), .tx_take(tx_take),
    .mode(mode), .enabled(enabled), .standby(standby), .settle_busy(settle_busy));
  nsb_host_model host (.mclk(mclk), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe), .pins(pins));

  // Monitor of latches, strobes and the receive stream
  always @(posedge mclk) begin
    if (cmd_out.valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd_out.value;
    end
    if (addr_out.valid === 1'b1) begin
      n_addr++;
      last_addr = addr_out.value;
    end
    if (cmd_refused === 1'b1) n_ref++;
    if (tx_take === 1'b1) begin
      // Byte on the bus must be the one offered at this take
      if (dq_out !== 8'(n_take)) n_dq_bad++;
      n_take++;
      tx_data <= tx_data + 8'h01;
    end
    if (dqs_oe === 1'b1 && dqs_out !== dqs_prev) n_tog++;
    dqs_prev <= dqs_out;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rx_q.push_back(rx_data);
  end

  // Byte and flag comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Mode comparison
  task automatic chk_m(input nsb_mode_t got, input nsb_mode_t exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: mode %b expected %b", $time, got, exp);
    end
  endtask : chk_m

  task automatic finish_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Select, settle, then idle
  task automatic t_enable();
    chk_m(mode, M_STANDBY);
    host.sel(1'b0);
    repeat (4) @(posedge mclk);
    chk(8'(enabled), 8'h00);
    host.idle(ENABLE_SETTLE_CYC + 2);
    chk_m(mode, M_IDLE);
    chk(8'(enabled), 8'h01);
    $display("enable test done");
  endtask : t_enable

  // Command and address bytes, then write guard codes
  task automatic t_latch();
    logic [7:0] codes[3] = '{8'h80, 8'h85, 8'h60};
    host.put(1'b1, 1'b0, 8'h90);
    chk(last_cmd, 8'h90);
    host.put(1'b0, 1'b1, 8'h3c);
    chk(last_addr, 8'h3c);
    chk(8'(n_cmd * 16 + n_addr), 8'h11);
    host.wp_n <= 1'b0;
    foreach (codes[i]) host.put(1'b1, 1'b0, codes[i]);
    chk(8'(n_ref * 16 + n_cmd), 8'h31);
    host.wp_n <= 1'b1;
    host.put(1'b1, 1'b0, 8'h80);
    chk(8'(n_ref * 16 + n_cmd), 8'h32);
    $display("latch test done");
  endtask : t_latch

  // Fill the receive buffer while stalled, then drain it
  task automatic t_rx();
    rx_ready <= 1'b0;
    host.din(34, 8'h40);
    chk(8'(rx_full), 8'h01);
    rx_ready <= 1'b1;
    for (int k = 0; k < 400 && rx_q.size() < 32; k++) @(posedge mclk);
    chk(8'(rx_q.size() >= 32), 8'h01);
    for (int i = 0; i < 32 && i < rx_q.size(); i++) chk(rx_q[i], 8'h40 + 8'(i));
    $display("receive test done");
  endtask : t_rx

  // Bus driving, data output, back to idle
  task automatic t_tx();
    int t0;
    int g0;
    tx_valid <= 1'b1;
    host.drive(MODE_SETTLE_CYC + 1);
    repeat (6) @(posedge mclk);
    chk_m(mode, M_DRIVE);
    chk(8'({dq_oe, dqs_out}), 8'h02);
    t0 = n_take;
    g0 = n_tog;
    host.dout(6);
    host.drive(2);
    host.idle(3);
    chk(8'(n_take - t0 >= 10), 8'h01);
    chk(8'(n_tog - g0 >= 10), 8'h01);
    chk(8'(n_dq_bad), 8'h00);
    chk(8'({dq_oe, dqs_oe}), 8'h00);
    $display("transmit test done");
  endtask : t_tx

  // Busy die takes only status traffic; deselect goes to standby mode, standby flag waits for ready
  task automatic t_busy();
    die_busy <= 1'b1;
    host.put(1'b1, 1'b0, 8'h90);
    chk(8'(n_cmd), 8'h02);
    chk(8'(rb_oe), 8'h01);
    host.put(1'b1, 1'b0, 8'h70);
    host.put(1'b0, 1'b1, 8'h11);
    chk(8'(n_cmd * 16 + n_addr), 8'h31);
    host.put(1'b1, 1'b0, 8'h78);
    host.put(1'b0, 1'b1, 8'h22);
    chk(8'(n_cmd * 16 + n_addr), 8'h42);
    chk(last_addr, 8'h22);
    host.sel(1'b1);
    repeat (8) @(posedge mclk);
    chk_m(mode, M_STANDBY);
    chk(8'(standby), 8'h00);
    die_busy <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(8'(standby), 8'h01);
    $display("busy test done");
  endtask : t_busy

  // Synchronous interface off: pins are ignored and nothing is driven
  task automatic t_passive();
    @(posedge mclk);
    sync_act <= 1'b0;
    host.sel(1'b0);
    host.drive(MODE_SETTLE_CYC + 1);
    repeat (6) @(posedge mclk);
    chk_m(mode, M_STANDBY);
    chk(8'({dq_oe, dqs_oe}), 8'h00);
    $display("passive test done");
  endtask : t_passive

  // Main sequence
  initial begin
    rst_n = 1'b0;
    die_busy = 1'b0;
    rx_ready = 1'b1;
    tx_valid = 1'b0;
    sync_act = 1'b1;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_enable();
    t_latch();
    t_rx();
    t_tx();
    t_busy();
    t_passive();
    finish_test();
  end

  // Hang guard
  initial begin
    #200us;
    failures++;
    $display("CHECK FAILED at %0t: run did not complete", $time);
    finish_test();
  end
endmodule : tb_top
